/* File: core/des_cfg_regs.sv */
// Shared configuration registers of the link deserializer with paged per-port regions.
//
// Functional notes
// - Read-to-clear fields clear after being read.
// - Self-clearing bits drop to zero by themselves.
// - Latched status holds its event until read.
// - Strap fields load from sampled strap pins.
// - Local port and control channel both reach registers.
// - Decode shared, video, equalizer and paged ranges.
// - Page field selects read port and write ports.
// - Test region paged per port; ID region shared.
// - Address field always reads the address in effect.
// - Source bit chooses strapped or written address.
// - Reload bit restarts configuration load, self-clears.
// - Full reset bit clears logic and registers.
// - Datapath reset bit keeps register contents.
// - Input override takes selection from register bit.
// - Select bit drives mode or mirrors select pin.
// - Output override hands outputs to register bits.
// - Output enable low with idle select floats outputs.
// - Idle select low forces driven-low while unlocked.
// - Init-done status set when configuration load ends.
`timescale 1ns/1ps
`include "des_cfg_map.svh"

module des_cfg_regs
  import des_cfg_pkg::*;
#(
  parameter int RELOAD_CYCLES = `RELOAD_CYCLES_DEF,
  parameter int NUM_RX        = 2
)(
  input  wire logic     sys_clk_i,
  input  wire logic     rst_b_i,
  input  wire reg_req_s local_req_i,
  input  wire reg_req_s remote_req_i,
  input  wire logic     sel_pin_i,
  input  wire logic     drive_outputs_pin_i,
  input  wire logic     idle_state_pin_i,
  input  wire logic     address_strap_pin_i,
  input  wire logic     link_lock_i,
  input  wire logic     link_pass_i,
  input  wire logic     cfg_cksum_ok_i,
  output reg_rsp_s      local_rsp_o,
  output reg_rsp_s      remote_rsp_o,
  output logic [6:0]    target_addr_o,
  output logic          input_sel_o,
  output logic          out_hiz_o,
  output logic          out_force_low_o,
  output logic          datapath_rst_o,
  output logic          reload_busy_o
);

  if (NUM_RX != 2) begin : g_bad_rx
    $error("The page field serves exactly two receive ports");
  end
  if (RELOAD_CYCLES < 1 || RELOAD_CYCLES > 65535) begin : g_bad_reload
    $error("RELOAD_CYCLES must lie in 1..65535");
  end

  // --------------------------------------------------------------------------
  // Internal reset and access arbitration
  // --------------------------------------------------------------------------
  logic [7:0] rst_ctl_reg, rst_ctl_next;
  logic       rst_int_b;

  assign rst_int_b = rst_b_i & ~rst_ctl_reg[`BIT_FULL_RESET];

  reg_req_s acc;
  logic     acc_remote;

  reg_access_arb u_arb (
    .local_req_i   (local_req_i),
    .remote_req_i  (remote_req_i),
    .local_busy_i  (local_rsp_o.ack),
    .remote_busy_i (remote_rsp_o.ack),
    .acc_o         (acc),
    .acc_remote_o  (acc_remote)
  );

  logic wr;
  logic rd;
  logic in_paged;
  logic in_shared_mem;
  logic [6:0] pidx;

  always_comb begin
    wr            = acc.valid & acc.write;
    rd            = acc.valid & ~acc.write;
    pidx          = {acc.addr[7], acc.addr[5:0]};
    in_paged      = (acc.addr >= `OFS_PAGED_LO && acc.addr <= `OFS_PAGED_HI) ||
                    (acc.addr >= `OFS_TEST_LO && acc.addr <= `OFS_TEST_HI);
    in_shared_mem = (acc.addr >= `OFS_SHARED_LO && acc.addr <= `OFS_SHARED_HI) ||
                    (acc.addr >= `OFS_VIDEO_LO && acc.addr <= `OFS_EQ_HI) ||
                    (acc.addr >= `OFS_INDIRECT_LO && acc.addr <= `OFS_INDIRECT_HI) ||
                    (acc.addr >= `OFS_RXID_LO && acc.addr <= `OFS_RXID_HI) ||
                    (acc.addr >= `OFS_PORTADDR_LO && acc.addr <= `OFS_PORTADDR_HI);
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers and strap capture
  // --------------------------------------------------------------------------
  logic [`PIN_COUNT-1:0] pin_meta_reg, pin_sync_reg;
  logic [1:0]            strap_cnt_reg, strap_cnt_next;
  logic [6:0]            strap_addr_reg, strap_addr_next;
  logic                  strap_done_reg, strap_done_next;

  always_comb begin
    strap_cnt_next  = strap_cnt_reg;
    strap_addr_next = strap_addr_reg;
    strap_done_next = strap_done_reg;
    if (!strap_done_reg) begin
      if (strap_cnt_reg == `STRAP_SETTLE) begin
        strap_done_next = 1'b1;
        strap_addr_next = pin_sync_reg[`PIN_STRAP] ? `RST_ALT_ADDR : `RST_TARGET_ADDR;
      end else begin
        strap_cnt_next = strap_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_int_b) begin
      pin_meta_reg   <= `RST_PIN_SYNC;
      pin_sync_reg   <= `RST_PIN_SYNC;
      strap_cnt_reg  <= 2'h0;
      strap_addr_reg <= `RST_TARGET_ADDR;
      strap_done_reg <= 1'b0;
    end else begin
      pin_meta_reg   <= {cfg_cksum_ok_i, link_pass_i, link_lock_i, address_strap_pin_i,
                         idle_state_pin_i, drive_outputs_pin_i, sel_pin_i};
      pin_sync_reg   <= pin_meta_reg;
      strap_cnt_reg  <= strap_cnt_next;
      strap_addr_reg <= strap_addr_next;
      strap_done_reg <= strap_done_next;
    end
  end

  // --------------------------------------------------------------------------
  // Shared control registers
  // --------------------------------------------------------------------------
  logic [7:0] addr_ctl_reg, addr_ctl_next;
  logic [7:0] gen_cfg_reg, gen_cfg_next;
  logic [7:0] page_reg, page_next;
  logic [6:0] eff_addr;
  logic       oe_eff;
  logic       idle_eff;
  logic       in_sel_eff;

  always_comb begin
    addr_ctl_next = addr_ctl_reg;
    gen_cfg_next  = gen_cfg_reg;
    page_next     = page_reg;
    rst_ctl_next  = {rst_ctl_reg[7:3], 3'h0};
    if (wr) begin
      unique case (acc.addr)
        `OFS_TARGET_ADDR: addr_ctl_next = acc.wdata;
        `OFS_SOFT_RESET:  rst_ctl_next  = acc.wdata;
        `OFS_GEN_CFG:     gen_cfg_next  = acc.wdata;
        `OFS_PAGE_SEL:    page_next     = acc.wdata;
        default: ;
      endcase
    end
    eff_addr   = addr_ctl_reg[`BIT_ADDR_SRC] ? addr_ctl_reg[7:1] : strap_addr_reg;
    in_sel_eff = gen_cfg_reg[`BIT_IN_OVERRIDE] ? gen_cfg_reg[`BIT_IN_SEL]
                                               : pin_sync_reg[`PIN_SEL];
    oe_eff     = gen_cfg_reg[`BIT_OUT_OVERRIDE] ? gen_cfg_reg[`BIT_OUT_ENABLE]
                                                : pin_sync_reg[`PIN_DRIVE];
    idle_eff   = gen_cfg_reg[`BIT_OUT_OVERRIDE] ? gen_cfg_reg[`BIT_IDLE_SEL]
                                                : pin_sync_reg[`PIN_IDLE];
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_int_b) begin
      addr_ctl_reg <= {`RST_TARGET_ADDR, 1'b0};
      gen_cfg_reg  <= `RST_GEN_CFG;
      page_reg     <= `RST_PAGE_SEL;
      rst_ctl_reg  <= `RST_SOFT_RESET;
    end else begin
      addr_ctl_reg <= addr_ctl_next;
      gen_cfg_reg  <= gen_cfg_next;
      page_reg     <= page_next;
      rst_ctl_reg  <= rst_ctl_next;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration load sequencer
  // --------------------------------------------------------------------------
  reload_state_e reload_state_reg, reload_state_next;
  logic [15:0]   reload_cnt_reg, reload_cnt_next;

  always_comb begin
    reload_state_next = reload_state_reg;
    reload_cnt_next   = reload_cnt_reg;
    unique case (reload_state_reg)
      RELOAD_RUN: begin
        if (reload_cnt_reg == 16'(RELOAD_CYCLES - 1)) begin
          reload_state_next = RELOAD_IDLE;
        end else begin
          reload_cnt_next = reload_cnt_reg + 16'h1;
        end
      end
      RELOAD_IDLE: begin
        if (rst_ctl_reg[`BIT_RELOAD]) begin
          reload_state_next = RELOAD_RUN;
          reload_cnt_next   = 16'h0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_int_b) begin
      reload_state_reg <= RELOAD_RUN;
      reload_cnt_reg   <= 16'h0;
    end else begin
      reload_state_reg <= reload_state_next;
      reload_cnt_reg   <= reload_cnt_next;
    end
  end

  // --------------------------------------------------------------------------
  // Device status with latched fields
  // --------------------------------------------------------------------------
  logic lock_lh_reg, lock_lh_next;
  logic pass_lh_reg, pass_lh_next;
  logic cksum_ll_reg, cksum_ll_next;
  logic rd_status;

  // A new event in the very cycle of the clearing read is kept.
  always_comb begin
    rd_status     = rd && acc.addr == `OFS_DEVICE_STATUS;
    lock_lh_next  = (lock_lh_reg & ~rd_status) | pin_sync_reg[`PIN_LOCK];
    pass_lh_next  = (pass_lh_reg & ~rd_status) | pin_sync_reg[`PIN_PASS];
    cksum_ll_next = (cksum_ll_reg | rd_status) & pin_sync_reg[`PIN_CKSUM];
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_int_b) begin
      lock_lh_reg  <= 1'b0;
      pass_lh_reg  <= 1'b0;
      cksum_ll_reg <= 1'b1;
    end else begin
      lock_lh_reg  <= lock_lh_next;
      pass_lh_reg  <= pass_lh_next;
      cksum_ll_reg <= cksum_ll_next;
    end
  end

  // --------------------------------------------------------------------------
  // Shared and per-port storage
  // --------------------------------------------------------------------------
  logic [7:0] shared_mem [256];
  logic [7:0] port_mem   [NUM_RX][128];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_int_b) begin
      for (int i = 0; i < 256; i++) begin
        shared_mem[i] <= 8'h00;
      end
    end else if (wr && in_shared_mem) begin
      shared_mem[acc.addr] <= acc.wdata;
    end
  end

  for (genvar p = 0; p < NUM_RX; p++) begin : g_port
    always_ff @(posedge sys_clk_i) begin
      if (!rst_int_b) begin
        for (int i = 0; i < 128; i++) begin
          port_mem[p][i] <= 8'h00;
        end
      end else if (wr && in_paged && page_reg[p]) begin
        port_mem[p][pidx] <= acc.wdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read data, answers and pin-facing outputs
  // --------------------------------------------------------------------------
  logic [7:0] rdata;
  reg_rsp_s   local_rsp_next;
  reg_rsp_s   remote_rsp_next;

  always_comb begin
    rdata = 8'h00;
    if (rd) begin
      if (in_paged) begin
        unique case (page_reg[5:4])
          2'h0:    rdata = port_mem[0][pidx];
          2'h1:    rdata = port_mem[1][pidx];
          default: rdata = 8'h00;
        endcase
      end else if (in_shared_mem) begin
        rdata = shared_mem[acc.addr];
      end else begin
        unique case (acc.addr)
          `OFS_TARGET_ADDR:   rdata = {eff_addr, addr_ctl_reg[`BIT_ADDR_SRC]};
          `OFS_SOFT_RESET:    rdata = rst_ctl_reg;
          `OFS_GEN_CFG:       rdata = {gen_cfg_reg[7], in_sel_eff, gen_cfg_reg[5:4],
                                       oe_eff, idle_eff, gen_cfg_reg[1:0]};
          `OFS_REVISION:      rdata = `RST_REVISION;
          `OFS_DEVICE_STATUS: rdata = {cksum_ll_reg, reload_state_reg == RELOAD_IDLE, 2'h0,
                                       pass_lh_reg, lock_lh_reg, 2'h0};
          `OFS_PAGE_SEL:      rdata = page_reg;
          default:            rdata = 8'h00;
        endcase
      end
    end
    local_rsp_next  = '{ack: acc.valid & ~acc_remote, rdata: rdata};
    remote_rsp_next = '{ack: acc.valid & acc_remote, rdata: rdata};
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_int_b) begin
      local_rsp_o     <= '0;
      remote_rsp_o    <= '0;
      target_addr_o   <= `RST_TARGET_ADDR;
      input_sel_o     <= 1'b0;
      out_hiz_o       <= 1'b0;
      out_force_low_o <= 1'b0;
      reload_busy_o   <= 1'b1;
      datapath_rst_o  <= 1'b0;
    end else begin
      local_rsp_o     <= local_rsp_next;
      remote_rsp_o    <= remote_rsp_next;
      target_addr_o   <= eff_addr;
      input_sel_o     <= in_sel_eff;
      out_hiz_o       <= ~oe_eff & idle_eff;
      out_force_low_o <= ~pin_sync_reg[`PIN_LOCK] & ~idle_eff;
      reload_busy_o   <= reload_state_next == RELOAD_RUN;
      datapath_rst_o  <= rst_ctl_next[`BIT_DP_RESET];
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  localparam int RELOAD_MAX = RELOAD_CYCLES + 2;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_int_b);

  sequence s_wr_reset_bit(int b);
    wr && acc.addr == `OFS_SOFT_RESET && acc.wdata[b];
  endsequence

  sequence s_sc_pulse(int b);
    rst_ctl_reg[b] ##1 !rst_ctl_reg[b];
  endsequence

  chk_rtc_clear: assert property (rd_status && !pin_sync_reg[`PIN_LOCK] |=> !lock_lh_reg)
    else $error("Latched lock bit not cleared by its read");
  chk_sc_reload: assert property (s_wr_reset_bit(`BIT_RELOAD) |=> s_sc_pulse(`BIT_RELOAD))
    else $error("Reload bit did not self-clear");
  chk_lh_hold: assert property (pin_sync_reg[`PIN_LOCK] |=> lock_lh_reg)
    else $error("Lock event not latched");
  chk_strap_load: assert property ($rose(strap_done_reg) |->
      strap_addr_reg == ($past(pin_sync_reg[`PIN_STRAP]) ? `RST_ALT_ADDR : `RST_TARGET_ADDR))
    else $error("Strapped address not taken from the strap pin");
  chk_ans_pair: assert property (acc.valid |=> local_rsp_o.ack != remote_rsp_o.ack)
    else $error("Access not answered to exactly one requester");
  chk_page_read: assert property (rd && in_paged && page_reg[5:4] == 2'h1 |=>
      remote_rsp_o.rdata == $past(port_mem[1][pidx]) || local_rsp_o.rdata == $past(port_mem[1][pidx]))
    else $error("Paged read not served by port one");
  chk_addr_read: assert property (rd && acc.addr == `OFS_TARGET_ADDR |=> (local_rsp_o.ack ?
      local_rsp_o.rdata[7:1] : remote_rsp_o.rdata[7:1]) == target_addr_o)
    else $error("Address read differs from address in effect");
  chk_addr_src: assert property (!addr_ctl_reg[`BIT_ADDR_SRC] |=> target_addr_o == $past(strap_addr_reg))
    else $error("Strapped address not in effect");
  // The full reset bit pulls the internal reset itself, so only the pin reset may disable this check.
  chk_full_reset: assert property (disable iff (!rst_b_i)
      s_wr_reset_bit(`BIT_FULL_RESET) |=> ##1 gen_cfg_reg == `RST_GEN_CFG)
    else $error("Full reset left registers unchanged");
  chk_dp_reset: assert property (s_wr_reset_bit(`BIT_DP_RESET) && !acc.wdata[`BIT_FULL_RESET] |=>
      datapath_rst_o ##1 !datapath_rst_o)
    else $error("Datapath reset not a single pulse");
  chk_in_override: assert property (gen_cfg_reg[`BIT_IN_OVERRIDE] |=> input_sel_o == $past(gen_cfg_reg[`BIT_IN_SEL]))
    else $error("Input override ignored");
  chk_hiz_out: assert property (!oe_eff && idle_eff |=> out_hiz_o)
    else $error("Outputs not floated");
  chk_init_done: assert property (rst_ctl_reg[`BIT_RELOAD] && reload_state_reg == RELOAD_IDLE |=>
      reload_state_reg == RELOAD_RUN ##[1:RELOAD_MAX] reload_state_reg == RELOAD_IDLE)
    else $error("Configuration load did not complete in time");

endmodule

/* File: core/des_cfg_map.svh */
// Register offsets, field positions, reset values and counts of the shared configuration registers.
`ifndef DES_CFG_MAP_SVH
`define DES_CFG_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets and decoded regions
// ----------------------------------------------------------------------------
`define OFS_TARGET_ADDR      8'h00
`define OFS_SOFT_RESET       8'h01
`define OFS_GEN_CFG          8'h02
`define OFS_REVISION         8'h03
`define OFS_DEVICE_STATUS    8'h04
`define OFS_SHARED_LO        8'h05
`define OFS_SHARED_HI        8'h31
`define OFS_VIDEO_LO         8'h3b
`define OFS_VIDEO_HI         8'h3f
`define OFS_EQ_LO            8'h40
`define OFS_EQ_HI            8'h43
`define OFS_PAGE_SEL         8'h4c
`define OFS_PAGED_LO         8'h4d
`define OFS_PAGED_HI         8'h7f
`define OFS_INDIRECT_LO      8'hb0
`define OFS_INDIRECT_HI      8'hbf
`define OFS_TEST_LO          8'hd0
`define OFS_TEST_HI          8'hdf
`define OFS_RXID_LO          8'hf0
`define OFS_RXID_HI          8'hf5
`define OFS_PORTADDR_LO      8'hf8
`define OFS_PORTADDR_HI      8'hfb

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_ADDR_SRC         0
`define BIT_DP_RESET         0
`define BIT_FULL_RESET       1
`define BIT_RELOAD           2
`define BIT_IN_OVERRIDE      7
`define BIT_IN_SEL           6
`define BIT_OUT_OVERRIDE     5
`define BIT_OUT_ENABLE       3
`define BIT_IDLE_SEL         2
`define BIT_ST_CKSUM         7
`define BIT_ST_INIT_DONE     6
`define BIT_ST_PASS          3
`define BIT_ST_LOCK          2

// Synchroniser lanes of the pin vector.
`define PIN_SEL              0
`define PIN_DRIVE            1
`define PIN_IDLE             2
`define PIN_STRAP            3
`define PIN_LOCK             4
`define PIN_PASS             5
`define PIN_CKSUM            6
`define PIN_COUNT            7
// The synchroniser resets to the idle levels of its pins, so no false event follows reset.
`define RST_PIN_SYNC         7'h46

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define RST_TARGET_ADDR      7'h3d
`define RST_ALT_ADDR         7'h36
`define RST_SOFT_RESET       8'h00
`define RST_GEN_CFG          8'h1e
`define RST_PAGE_SEL         8'h01
`define RST_REVISION         8'h00
`define STRAP_SETTLE         2'h2
`define RELOAD_CYCLES_DEF    64

`endif

/* File: core/des_cfg_pkg.sv */
// Types shared by the configuration register front end.
package des_cfg_pkg;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } reg_rsp_s;

  typedef enum logic {
    RELOAD_RUN,
    RELOAD_IDLE
  } reload_state_e;

endpackage

/* File: core/reg_access_arb.sv */
// Arbiter that merges the local target port and the control channel into one access.
`timescale 1ns/1ps

module reg_access_arb
  import des_cfg_pkg::*;
(
  input  wire reg_req_s local_req_i,
  input  wire reg_req_s remote_req_i,
  input  wire logic     local_busy_i,
  input  wire logic     remote_busy_i,
  output reg_req_s      acc_o,
  output logic          acc_remote_o
);

  logic local_go;
  logic remote_go;

  // The local port wins a tie. It cannot starve the channel, because the
  // cycle in which its answer stands blocks it and leaves the channel a turn.
  always_comb begin
    local_go     = local_req_i.valid & ~local_busy_i;
    remote_go    = remote_req_i.valid & ~remote_busy_i;
    acc_o        = local_go ? local_req_i : remote_req_i;
    acc_o.valid  = local_go | remote_go;
    acc_remote_o = ~local_go & remote_go;
  end

endmodule

/* File: dv/reg_host_model.sv */
// Requester model for the local target port or the control channel.
`timescale 1ns/1ps

module reg_host_model
  import des_cfg_pkg::*;
(
  input  wire logic     sys_clk_i,
  input  wire reg_rsp_s rsp_i,
  output reg_req_s      req_o
);
  initial req_o = '0;

  // Holds the request until ack or for at most 20 cycles, then drops it and scrambles the released fields.
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
    int n;
    ok = 1'b0;
    q  = 8'h00;
    @(negedge sys_clk_i);
    req_o = '{valid: 1'b1, write: wr, addr: a, wdata: d};
    for (n = 0; n < 20 && !ok; n++) begin
      @(negedge sys_clk_i);
      if (rsp_i.ack === 1'b1) begin
        ok = 1'b1;
        q  = rsp_i.rdata;
      end
    end
    req_o = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
  endtask
endmodule

/* File: dv/test_des_cfg_regs.sv */
// Self-checking testbench of the shared configuration registers.
`timescale 1ns/1ps

module test_des_cfg_regs;
  import des_cfg_pkg::*;
  localparam int RELOAD = 4;
  logic       sys_clk_i = 1'b0;
  logic       rst_b_i   = 1'b0;
  logic       sel = 1'b0, drive_pin = 1'b1, idle = 1'b1, strap = 1'b0;
  logic       lock = 1'b0, pass = 1'b0, cksum = 1'b1;
  reg_req_s   local_req, remote_req;
  reg_rsp_s   local_rsp, remote_rsp;
  logic [6:0] target;
  logic       in_sel, hiz, force_low, dp_rst, busy, busy_q;
  logic [7:0] q;
  logic [7:0] tbl [6] = '{8'h05, 8'h31, 8'h3b, 8'h3f, 8'h40, 8'h43};
  int         fail_count = 0, compares = 0, dp_pulses = 0, busy_rises = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  des_cfg_regs #(.RELOAD_CYCLES(RELOAD), .NUM_RX(2)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .local_req_i(local_req), .remote_req_i(remote_req),
    .sel_pin_i(sel), .drive_outputs_pin_i(drive_pin), .idle_state_pin_i(idle), .address_strap_pin_i(strap),
    .link_lock_i(lock), .link_pass_i(pass), .cfg_cksum_ok_i(cksum), .local_rsp_o(local_rsp),
    .remote_rsp_o(remote_rsp), .target_addr_o(target), .input_sel_o(in_sel), .out_hiz_o(hiz),
    .out_force_low_o(force_low), .datapath_rst_o(dp_rst), .reload_busy_o(busy));
  reg_host_model u_loc (.sys_clk_i(sys_clk_i), .rsp_i(local_rsp), .req_o(local_req));
  reg_host_model u_rem (.sys_clk_i(sys_clk_i), .rsp_i(remote_rsp), .req_o(remote_req));

  always @(negedge sys_clk_i) begin
    busy_q <= busy;
    if (dp_rst === 1'b1) dp_pulses++;
    if (busy === 1'b1 && busy_q === 1'b0) busy_rises++;
  end

  // ----------------------------------------------------------------------------
  // Access and comparison tasks
  // ----------------------------------------------------------------------------
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A full reset may swallow its own ack, so that write does not insist on one.
  task automatic xfer(input bit rem, input bit wr, input logic [7:0] a, input logic [7:0] d, input bit need);
    logic ok;
    if (rem) u_rem.access(wr, a, d, q, ok);
    else u_loc.access(wr, a, d, q, ok);
    if (!ok && need) begin
      fail_count++;
      $display("[ERR] %0t no ack at %h", $time, a);
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b0, 1'b1, a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, 1'b0, a, 8'h00, 1'b1);
    check(q, exp);
  endtask

  // Pins pass a two-flop synchroniser, so four cycles let them settle.
  task automatic settle();
    repeat (4) @(negedge sys_clk_i);
  endtask

  task automatic wait_init();
    int n;
    for (n = 0; n < 40; n++) begin
      xfer(1'b0, 1'b0, 8'h04, 8'h00, 1'b1);
      if (q[6] === 1'b1) break;
    end
    check(q & 8'h40, 8'h40);
  endtask

  initial begin
    int b;
    repeat (5) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    rd(8'h00, 8'h7a);
    check({1'b0, target}, 8'h3d);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h1e);
    rd(8'h4c, 8'h01);
    wait_init();
    rd(8'h04, 8'hc0);
    lock = 1'b1;
    pass = 1'b1;
    settle();
    lock = 1'b0;
    pass = 1'b0;
    cksum = 1'b0;
    settle();
    cksum = 1'b1;
    settle();
    rd(8'h04, 8'h4c);
    rd(8'h04, 8'hc0);
    wr(8'h00, 8'h41);
    rd(8'h00, 8'h41);
    check({1'b0, target}, 8'h20);
    b = dp_pulses;
    wr(8'h01, 8'hf9);
    rd(8'h01, 8'hf8);
    check(8'(dp_pulses - b), 8'h01);
    rd(8'h00, 8'h41);
    wr(8'h00, 8'h40);
    rd(8'h00, 8'h7a);
    b = busy_rises;
    wr(8'h01, 8'h04);
    wait_init();
    check(8'(busy_rises - b), 8'h01);
    rd(8'h01, 8'h00);
    wr(8'h02, 8'hd0);
    settle();
    rd(8'h02, 8'hdc);
    check({7'h0, in_sel}, 8'h01);
    wr(8'h02, 8'h50);
    settle();
    rd(8'h02, 8'h1c);
    check({7'h0, in_sel}, 8'h00);
    wr(8'h02, 8'h34);
    settle();
    check({6'h0, hiz, force_low}, 8'h02);
    wr(8'h02, 8'h30);
    settle();
    check({6'h0, hiz, force_low}, 8'h01);
    wr(8'h02, 8'h10);
    drive_pin = 1'b0;
    settle();
    rd(8'h02, 8'h14);
    check({6'h0, hiz, force_low}, 8'h02);
    drive_pin = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(8'h4c, 8'(1 << i));
      wr(8'h50, 8'h5a ^ 8'(i));
      wr(8'hd3, 8'ha5 ^ 8'(i));
    end
    for (int i = 0; i < 2; i++) begin
      wr(8'h4c, 8'(i << 4));
      rd(8'h50, 8'h5a ^ 8'(i));
      rd(8'hd3, 8'ha5 ^ 8'(i));
    end
    wr(8'h4c, 8'h03);
    wr(8'h51, 8'h77);
    rd(8'h51, 8'h77);
    wr(8'h4c, 8'h10);
    rd(8'h51, 8'h77);
    wr(8'h4c, 8'h20);
    rd(8'h51, 8'h00);
    wr(8'hf2, 8'h3c);
    wr(8'h4c, 8'h00);
    rd(8'hf2, 8'h3c);
    foreach (tbl[i]) begin
      wr(tbl[i], 8'h90 + 8'(i));
      rd(tbl[i], 8'h90 + 8'(i));
    end
    wr(8'h32, 8'hff);
    rd(8'h32, 8'h00);
    fork
      xfer(1'b1, 1'b1, 8'h06, 8'h6e, 1'b1);
      wr(8'h07, 8'he6);
    join
    xfer(1'b1, 1'b0, 8'h07, 8'h00, 1'b1);
    check(q, 8'he6);
    rd(8'h06, 8'h6e);
    strap = 1'b1;
    wr(8'h4c, 8'h12);
    xfer(1'b0, 1'b1, 8'h01, 8'h02, 1'b0);
    settle();
    wait_init();
    rd(8'h00, 8'h6c);
    rd(8'h4c, 8'h01);
    rd(8'h01, 8'h00);
    close_out();
  end
endmodule
